// File: dv/aemi_ctrl_tb.sv
// self-checking bench for the async memory controller
`timescale 1ns/1ps
`default_nettype none
module aemi_ctrl_tb;
  logic        clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0;
  logic        pwrite = 1'h0, req_valid = 1'h0, req_write = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, req_wdata = 32'h0, prdata, rsp_rdata, rd;
  logic [1:0]  req_space = 2'h0, req_size = 2'h0, bank_addr_lsb, cap_b;
  logic [24:0] req_addr = 25'h0;
  logic        pready, pslverr, req_ready, rsp_valid, ext_data_oe, se;
  logic        read_strobe_n, write_strobe_n, read_write_sel, wait_in;
  logic        wait_pol = 1'h1, seen = 1'h0, ss_bad = 1'h0, rw_bad = 1'h0;
  logic [3:0]  space_select_n;
  logic [21:0] ext_word_addr, cap_a;
  logic [15:0] ext_data_in, ext_data_bus;
  logic [7:0]  wait_len = 8'h00;
  int          errors = 0, n_compared = 0, lat, c_pre, c_str, c_post;
  wire  logic  strb = ~(read_strobe_n & write_strobe_n);
  wire  logic  sel = ~&space_select_n;

  aemi_ctrl DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_space(req_space),
    .req_addr(req_addr), .req_size(req_size), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .space_select_n(space_select_n), .ext_word_addr(ext_word_addr),
    .bank_addr_lsb(bank_addr_lsb), .ext_data_in(ext_data_in),
    .ext_data_bus(ext_data_bus), .ext_data_oe(ext_data_oe),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .read_write_sel(read_write_sel), .wait_in(wait_in));
  aemi_mem MEM (.clk(clk), .space_select_n(space_select_n),
    .ext_word_addr(ext_word_addr), .bank_addr_lsb(bank_addr_lsb),
    .ext_data_bus(ext_data_bus), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .wait_pol(wait_pol),
    .wait_len(wait_len), .ext_data_in(ext_data_in), .wait_in(wait_in));

  initial forever #2.5 clk = ~clk;

  // phase counters and pin snapshots per request
  always @(posedge clk)
  begin
    if (sel && !strb && !seen) c_pre++;
    if (sel && !strb && seen) c_post++;
    if (strb)
    begin
      c_str++;
      seen = 1'h1;
      cap_a = ext_word_addr;
      cap_b = bank_addr_lsb;
    end
    if (!space_select_n[1] && !strb) ss_bad = 1'h1;
    if (!read_strobe_n && !read_write_sel) rw_bad = 1'h1;
    if (!write_strobe_n && read_write_sel) rw_bad = 1'h1;
  end

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic test_done;
    if (errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'h1);
    rd = prdata;
    se = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic mreq(input logic w, input logic [1:0] sp, input logic [24:0] a,
                      input logic [1:0] sz, input logic [31:0] d);
    lat = 0;
    @(negedge clk);
    c_pre = 0;
    c_str = 0;
    c_post = 0;
    seen = 1'h0;
    @(posedge clk);
    req_valid <= 1'h1;
    req_write <= w;
    req_space <= sp;
    req_addr <= a;
    req_size <= sz;
    req_wdata <= d;
    do
    begin
      @(posedge clk);
    end
    while (req_ready !== 1'h1);
    req_valid <= 1'h0;
    do
    begin
      @(posedge clk);
      lat++;
    end
    while (rsp_valid !== 1'h1);
    rd = rsp_rdata;
  endtask

  function automatic logic [31:0] cfg(input logic [31:0] ss, ew, wsu, wst,
                                      whd, rsu, rst, rhd, ta, w16);
    return (ss << aemi_pkg::CFG_SS) | (ew << aemi_pkg::CFG_EW)
      | (wsu << aemi_pkg::CFG_WSU_LO) | (wst << aemi_pkg::CFG_WST_LO)
      | (whd << aemi_pkg::CFG_WHD_LO) | (rsu << aemi_pkg::CFG_RSU_LO)
      | (rst << aemi_pkg::CFG_RST_LO) | (rhd << aemi_pkg::CFG_RHD_LO)
      | (ta << aemi_pkg::CFG_TA_LO) | (w16 << aemi_pkg::CFG_WIDTH_LO);
  endfunction

  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    test_done;
  end

  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    apb(1'h0, aemi_pkg::ADDR_CFG0, 32'h0);
    chk("cfg0 reset", aemi_pkg::CFG_RESET, rd);
    apb(1'h0, aemi_pkg::ADDR_WAITCFG, 32'h0);
    chk("wait cfg reset", aemi_pkg::WCFG_RESET, rd);
    apb(1'h0, 12'hffc, 32'h0);
    chk("unmapped data", 32'h0, rd);
    chk("unmapped err", 32'h1, 32'(se));
    for (int n = 0; n < 4; n++)
      apb(1'h1, aemi_pkg::ADDR_CFG0 + 12'(4 * n), 32'h12345670 + 32'(n));
    for (int n = 0; n < 4; n++)
    begin
      apb(1'h0, aemi_pkg::ADDR_CFG0 + 12'(4 * n), 32'h0);
      chk("cfg readback", 32'h12345670 + 32'(n), rd);
    end
    apb(1'h1, aemi_pkg::ADDR_CFG0, cfg(0, 0, 1, 2, 2, 2, 3, 1, 2, 1));
    apb(1'h1, aemi_pkg::ADDR_CFG0 + 12'h4, cfg(1, 0, 1, 2, 2, 2, 3, 1, 2, 1));
    apb(1'h1, aemi_pkg::ADDR_CFG0 + 12'h8, cfg(0, 0, 0, 1, 0, 0, 0, 0, 0, 0));
    apb(1'h1, aemi_pkg::ADDR_CFG0 + 12'hc, cfg(0, 1, 0, 2, 0, 0, 2, 0, 0, 1));
    mreq(1'h1, 2'h0, 25'h1000006, 2'h1, 32'h0000beef);
    mreq(1'h1, 2'h0, 25'h1000006, 2'h1, 32'h0000c3a5);
    chk("write latency", 32'h9, 32'(lat));
    chk("write setup", 32'h2, 32'(c_pre));
    chk("write strobe", 32'h3, 32'(c_str));
    chk("write hold", 32'h3, 32'(c_post));
    chk("word addr", 32'h1, 32'(cap_a));
    chk("bank addr", 32'h3, 32'(cap_b));
    mreq(1'h0, 2'h0, 25'h1000006, 2'h1, 32'h0);
    chk("read turnaround", 32'hd, 32'(lat));
    chk("read data", 32'hc3a5, 32'(rd[31:16]));
    chk("read setup", 32'h3, 32'(c_pre));
    chk("read strobe", 32'h4, 32'(c_str));
    chk("read hold", 32'h2, 32'(c_post));
    mreq(1'h0, 2'h0, 25'h1000006, 2'h1, 32'h0);
    chk("read latency", 32'ha, 32'(lat));
    mreq(1'h1, 2'h1, 25'h10, 2'h1, 32'h00005a5a);
    mreq(1'h0, 2'h1, 25'h10, 2'h1, 32'h0);
    chk("strobe mode data", 32'h5a5a, 32'(rd[31:16]));
    chk("strobe mode setup", 32'h0, 32'(c_pre));
    mreq(1'h1, 2'h2, 25'h20, 2'h2, 32'h89abcdef);
    chk("byte beats", 32'h8, 32'(c_str));
    mreq(1'h0, 2'h2, 25'h20, 2'h2, 32'h0);
    chk("byte data", 32'h89abcdef, rd);
    apb(1'h1, aemi_pkg::ADDR_WAITCFG, 32'h10000000);
    wait_len <= 8'h64;
    mreq(1'h0, 2'h3, 25'h40, 2'h1, 32'h0);
    apb(1'h0, aemi_pkg::ADDR_STATUS, 32'h0);
    chk("timeout flag", 32'h1, rd);
    apb(1'h1, aemi_pkg::ADDR_STATUS, 32'h1);
    apb(1'h0, aemi_pkg::ADDR_STATUS, 32'h0);
    chk("timeout clear", 32'h0, rd);
    for (int p = 0; p < 2; p++)
    begin
      wait_pol <= p[0];
      wait_len <= 8'h06;
      apb(1'h1, aemi_pkg::ADDR_WAITCFG, {3'h0, p[0], 28'h00000ff});
      mreq(1'h0, 2'h3, 25'h40, 2'h1, 32'h0);
      chk("wait stretch", 32'h1, 32'(c_str > 5 && c_str < 14));
    end
    apb(1'h1, aemi_pkg::ADDR_CFG0, cfg(0, 0, 1, 2, 2, 2, 3, 1, 2, 1) |
        (32'h1 << aemi_pkg::CFG_NAND));
    mreq(1'h1, 2'h0, 25'h8, 2'h1, 32'h00001234);
    apb(1'h0, aemi_pkg::ADDR_ECC, 32'h0);
    chk("ecc parity", 32'h1234, rd);
    chk("select outside strobe", 32'h0, 32'(ss_bad));
    chk("direction pin", 32'h0, 32'(rw_bad));
    test_done;
  end
endmodule
`default_nettype wire

// File: dv/aemi_mem.sv
// memory device model on the far side of the async controller
`timescale 1ns/1ps
`default_nettype none
module aemi_mem
(
  input  wire logic        clk,
  input  wire logic [3:0]  space_select_n,
  input  wire logic [21:0] ext_word_addr,
  input  wire logic [1:0]  bank_addr_lsb,
  input  wire logic [15:0] ext_data_bus,
  input  wire logic        read_strobe_n,
  input  wire logic        write_strobe_n,
  input  wire logic        wait_pol,
  input  wire logic [7:0]  wait_len,
  output logic      [15:0] ext_data_in,
  output logic             wait_in
);
  logic [15:0] mem [0:63];
  logic [15:0] last = 16'h0000;
  logic [7:0]  wcnt = 8'h00;
  wire  logic [5:0] idx = {ext_word_addr[3:0], bank_addr_lsb};
  wire  logic sel = ~&space_select_n;
  wire  logic strb = ~(read_strobe_n & write_strobe_n);
  wire  logic busy = strb && (wcnt < wait_len);
  // wait held for wait_len strobe cycles, level per polarity
  assign wait_in = wait_pol ? busy : ~busy;
  // data only while selected and read strobe low, else changing
  assign ext_data_in = (sel && !read_strobe_n) ? mem[idx] : ~last;
  always @(posedge clk)
  begin
    last <= ext_data_in;
    wcnt <= strb ? wcnt + 8'h01 : 8'h00;
    if (sel && !write_strobe_n)
      mem[idx] <= ext_data_bus;
  end
endmodule
`default_nettype wire

// File: rtl/aemi_ctrl.sv
// async external memory controller with apb registers
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module aemi_ctrl
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic        req_write,
  input  wire logic [1:0]  req_space,
  input  wire logic [24:0] req_addr,
  input  wire logic [1:0]  req_size,
  input  wire logic [31:0] req_wdata,
  output logic             rsp_valid,
  output logic      [31:0] rsp_rdata,
  output logic      [3:0]  space_select_n,
  output logic      [21:0] ext_word_addr,
  output logic      [1:0]  bank_addr_lsb,
  input  wire logic [15:0] ext_data_in,
  output logic      [15:0] ext_data_bus,
  output logic             ext_data_oe,
  output logic             read_strobe_n,
  output logic             write_strobe_n,
  output logic             read_write_sel,
  input  wire logic        wait_in
);
  typedef enum logic [2:0] {AEMI_IDLE, AEMI_TURN, AEMI_SETUP, AEMI_STROBE,
                            AEMI_HOLD} aemi_state_e;

  function automatic logic [5:0] aemi_fld(input logic [31:0] c, input int lo,
                                          input int w);
    aemi_fld = 6'((c >> lo) & ((32'h1 << w) - 32'h1));
  endfunction

  logic [31:0] cfg_ff [4];
  logic [31:0] nxt_cfg [4];
  logic [31:0] wcfg_ff, nxt_wcfg;
  logic        tmo_ff, nxt_tmo;
  logic [31:0] ecc_ff, nxt_ecc;
  logic [9:0]  ecc_cnt_ff, nxt_ecc_cnt;
  logic [31:0] prdata_ff, nxt_prdata;
  logic        w1_ff, w2_ff;
  logic [31:0] acfg_ff, nxt_acfg;
  aemi_state_e st_ff, nxt_st;
  logic [5:0]  cnt_ff, nxt_cnt;
  logic [11:0] wcnt_ff, nxt_wcnt;
  logic        wr_ff, nxt_wr;
  logic [1:0]  sp_ff, nxt_sp;
  logic [24:0] addr_ff, nxt_addr;
  logic [2:0]  beats_ff, nxt_beats;
  logic [31:0] data_ff, nxt_data;
  logic        lastv_ff, nxt_lastv;
  logic        lastwr_ff, nxt_lastwr;
  logic [1:0]  lastsp_ff, nxt_lastsp;
  logic        rsp_ff, nxt_rsp;
  logic        apb_wr, wide, wait_act, tmo_hit;
  logic [2:0]  need;

  assign pready  = 1'b1;
  assign apb_wr  = psel && penable && pwrite;
  assign pslverr = psel && penable && !(paddr == aemi_pkg::ADDR_WAITCFG ||
                   paddr == aemi_pkg::ADDR_STATUS || paddr == aemi_pkg::ADDR_ECC
                   || (paddr[11:4] == aemi_pkg::ADDR_CFG0[11:4]
                   && paddr[1:0] == 2'h0));
  assign prdata = prdata_ff;

  // register file
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      nxt_cfg[i] = cfg_ff[i];
      if (apb_wr && paddr == aemi_pkg::ADDR_CFG0 + 12'(i * 4))
        nxt_cfg[i] = pwdata;
    end
    nxt_wcfg = (apb_wr && paddr == aemi_pkg::ADDR_WAITCFG) ? pwdata : wcfg_ff;
    nxt_tmo = tmo_ff;
    if (apb_wr && paddr == aemi_pkg::ADDR_STATUS && pwdata[0])
      nxt_tmo = 1'b0;
    if (tmo_hit)
      nxt_tmo = 1'b1;
    nxt_prdata = 32'h0;
    if (psel && !penable)
    begin
      if (paddr == aemi_pkg::ADDR_WAITCFG)
        nxt_prdata = wcfg_ff;
      else if (paddr == aemi_pkg::ADDR_STATUS)
        nxt_prdata = {31'h0, tmo_ff};
      else if (paddr == aemi_pkg::ADDR_ECC)
        nxt_prdata = ecc_ff;
      else if (paddr[11:4] == aemi_pkg::ADDR_CFG0[11:4])
        nxt_prdata = cfg_ff[paddr[3:2]];
    end
    else if (psel)
      nxt_prdata = prdata_ff;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 4; i++)
        cfg_ff[i] <= aemi_pkg::CFG_RESET;
      wcfg_ff   <= aemi_pkg::WCFG_RESET;
      tmo_ff    <= 1'b0;
      prdata_ff <= 32'h0;
    end
    else
    begin
      cfg_ff    <= nxt_cfg;
      wcfg_ff   <= nxt_wcfg;
      tmo_ff    <= nxt_tmo;
      prdata_ff <= nxt_prdata;
    end
  end

  // wait synchroniser
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      w1_ff <= 1'b0;
      w2_ff <= 1'b0;
    end
    else
    begin
      w1_ff <= wait_in;
      w2_ff <= w1_ff;
    end
  end

  assign wait_act = acfg_ff[aemi_pkg::CFG_EW] &&
                    (w2_ff == wcfg_ff[aemi_pkg::WCFG_POL]);
  assign tmo_hit  = st_ff == AEMI_STROBE && wait_act &&
                    wcnt_ff == {wcfg_ff[7:0], 4'hf};
  assign wide     = nxt_cfg[req_space][aemi_pkg::CFG_WIDTH_LO];
  assign need     = req_size == 2'h0 ? 3'h1 : req_size == 2'h1 ?
                    (wide ? 3'h1 : 3'h2) : (wide ? 3'h2 : 3'h4);
  assign req_ready = st_ff == AEMI_IDLE;
  assign rsp_valid = rsp_ff;
  assign rsp_rdata = data_ff;

  // access sequencer
  always_comb
  begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_wcnt = wcnt_ff;
    nxt_wr = wr_ff;
    nxt_sp = sp_ff;
    nxt_addr = addr_ff;
    nxt_beats = beats_ff;
    nxt_data = data_ff;
    nxt_acfg = acfg_ff;
    nxt_lastv = lastv_ff;
    nxt_lastwr = lastwr_ff;
    nxt_lastsp = lastsp_ff;
    nxt_rsp = 1'b0;
    case (st_ff)
      AEMI_IDLE:
        if (req_valid)
        begin
          nxt_acfg = nxt_cfg[req_space];
          nxt_wr = req_write;
          nxt_sp = req_space;
          nxt_addr = req_addr;
          nxt_beats = need;
          nxt_data = req_wdata;
          if (lastv_ff && !(lastwr_ff == req_write && lastsp_ff == req_space))
          begin
            nxt_st = AEMI_TURN;
            nxt_cnt = aemi_fld(nxt_acfg, aemi_pkg::CFG_TA_LO, 2);
          end
          else
          begin
            nxt_st = AEMI_SETUP;
            nxt_cnt = aemi_fld(nxt_acfg, req_write ? aemi_pkg::CFG_WSU_LO :
                               aemi_pkg::CFG_RSU_LO, 4);
          end
        end
      AEMI_TURN:
        if (cnt_ff == 6'h0)
        begin
          nxt_st = AEMI_SETUP;
          nxt_cnt = aemi_fld(acfg_ff, wr_ff ? aemi_pkg::CFG_WSU_LO :
                             aemi_pkg::CFG_RSU_LO, 4);
        end
        else
          nxt_cnt = cnt_ff - 6'h1;
      AEMI_SETUP:
        if (cnt_ff == 6'h0)
        begin
          nxt_st = AEMI_STROBE;
          nxt_wcnt = 12'h0;
          nxt_cnt = aemi_fld(acfg_ff, wr_ff ? aemi_pkg::CFG_WST_LO :
                             aemi_pkg::CFG_RST_LO, 6);
        end
        else
          nxt_cnt = cnt_ff - 6'h1;
      AEMI_STROBE:
      begin
        if (cnt_ff != 6'h0)
          nxt_cnt = cnt_ff - 6'h1;
        if (wait_act && !tmo_hit)
          nxt_wcnt = wcnt_ff + 12'h1;
        if ((cnt_ff == 6'h0 && !wait_act) || tmo_hit)
        begin
          nxt_st = AEMI_HOLD;
          nxt_cnt = aemi_fld(acfg_ff, wr_ff ? aemi_pkg::CFG_WHD_LO :
                             aemi_pkg::CFG_RHD_LO, 3);
          if (!wr_ff)
            nxt_data = acfg_ff[aemi_pkg::CFG_WIDTH_LO] ?
                       {ext_data_in, data_ff[31:16]} :
                       {ext_data_in[7:0], data_ff[31:8]};
        end
      end
      AEMI_HOLD:
        if (cnt_ff == 6'h0)
        begin
          nxt_beats = beats_ff - 3'h1;
          nxt_lastv = 1'b1;
          nxt_lastwr = wr_ff;
          nxt_lastsp = sp_ff;
          if (wr_ff)
            nxt_data = acfg_ff[aemi_pkg::CFG_WIDTH_LO] ?
                       {16'h0, data_ff[31:16]} : {8'h0, data_ff[31:8]};
          if (beats_ff == 3'h1)
          begin
            nxt_st = AEMI_IDLE;
            nxt_rsp = 1'b1;
            if (!wr_ff)
              nxt_data = acfg_ff[aemi_pkg::CFG_WIDTH_LO] ?
                         (need_shift(beats_ff) ? data_ff : data_ff) : data_ff;
          end
          else
          begin
            nxt_st = AEMI_SETUP;
            nxt_addr = addr_ff + (acfg_ff[aemi_pkg::CFG_WIDTH_LO] ?
                                  25'h2 : 25'h1);
            nxt_cnt = aemi_fld(acfg_ff, wr_ff ? aemi_pkg::CFG_WSU_LO :
                               aemi_pkg::CFG_RSU_LO, 4);
          end
        end
        else
          nxt_cnt = cnt_ff - 6'h1;
      default:
        nxt_st = AEMI_IDLE;
    endcase
  end

  function automatic logic need_shift(input logic [2:0] b);
    need_shift = b == 3'h0;
  endfunction

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_ff     <= AEMI_IDLE;
      cnt_ff    <= 6'h0;
      wcnt_ff   <= 12'h0;
      wr_ff     <= 1'b0;
      sp_ff     <= 2'h0;
      addr_ff   <= 25'h0;
      beats_ff  <= 3'h0;
      data_ff   <= 32'h0;
      acfg_ff   <= 32'h0;
      lastv_ff  <= 1'b0;
      lastwr_ff <= 1'b0;
      lastsp_ff <= 2'h0;
      rsp_ff    <= 1'b0;
    end
    else
    begin
      st_ff     <= nxt_st;
      cnt_ff    <= nxt_cnt;
      wcnt_ff   <= nxt_wcnt;
      wr_ff     <= nxt_wr;
      sp_ff     <= nxt_sp;
      addr_ff   <= nxt_addr;
      beats_ff  <= nxt_beats;
      data_ff   <= nxt_data;
      acfg_ff   <= nxt_acfg;
      lastv_ff  <= nxt_lastv;
      lastwr_ff <= nxt_lastwr;
      lastsp_ff <= nxt_lastsp;
      rsp_ff    <= nxt_rsp;
    end
  end

  // nand ecc: column parity over each block of 512 bus transfers
  always_comb
  begin
    nxt_ecc = ecc_ff;
    nxt_ecc_cnt = ecc_cnt_ff;
    if (st_ff == AEMI_HOLD && cnt_ff == 6'h0 &&
        acfg_ff[aemi_pkg::CFG_NAND])
    begin
      if (ecc_cnt_ff == 10'h0)
        nxt_ecc = 32'h0;
      else
        nxt_ecc = ecc_ff;
      nxt_ecc = nxt_ecc ^ {16'h0, wr_ff ? data_ff[15:0] : data_ff[31:16]};
      nxt_ecc_cnt = (ecc_cnt_ff + 10'h1 == aemi_pkg::ECC_BYTES) ? 10'h0 :
                    ecc_cnt_ff + 10'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ecc_ff     <= 32'h0;
      ecc_cnt_ff <= 10'h0;
    end
    else
    begin
      ecc_ff     <= nxt_ecc;
      ecc_cnt_ff <= nxt_ecc_cnt;
    end
  end

  // pins driven from registered state
  always_comb
  begin
    space_select_n = 4'hf;
    if (st_ff == AEMI_STROBE ||
        (!acfg_ff[aemi_pkg::CFG_SS] &&
         (st_ff == AEMI_SETUP || st_ff == AEMI_HOLD)))
      space_select_n[sp_ff] = 1'b0;
  end
  assign ext_word_addr  = addr_ff[23:2];
  assign bank_addr_lsb  = acfg_ff[aemi_pkg::CFG_WIDTH_LO] ?
                          {addr_ff[1], addr_ff[24]} : addr_ff[1:0];
  assign ext_data_bus   = data_ff[15:0];
  assign ext_data_oe    = wr_ff && st_ff inside {AEMI_SETUP, AEMI_STROBE,
                                                 AEMI_HOLD};
  assign read_strobe_n  = !(st_ff == AEMI_STROBE && !wr_ff);
  assign write_strobe_n = !(st_ff == AEMI_STROBE && wr_ff);
  assign read_write_sel = !wr_ff;

  strobe_len_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(read_strobe_n) && !acfg_ff[aemi_pkg::CFG_EW] &&
    aemi_fld(acfg_ff, aemi_pkg::CFG_RST_LO, 6) == 6'h0 |=> read_strobe_n)
    else $error("read strobe too long");
  ss_select_a: assert property (@(posedge clk) disable iff (!rst_n)
    acfg_ff[aemi_pkg::CFG_SS] && st_ff == AEMI_SETUP |-> &space_select_n)
    else $error("select active in setup in strobe mode");
  normal_select_a: assert property (@(posedge clk) disable iff (!rst_n)
    !acfg_ff[aemi_pkg::CFG_SS] && st_ff == AEMI_HOLD |-> !(&space_select_n))
    else $error("select dropped in hold");
  rw_level_a: assert property (@(posedge clk) disable iff (!rst_n)
    !write_strobe_n |-> !read_write_sel)
    else $error("rw select high during write");
  data_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
    !write_strobe_n |-> $past(ext_data_oe))
    else $error("write data not set up");
  tmo_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    tmo_hit |=> tmo_ff && st_ff == AEMI_HOLD)
    else $error("timeout not flagged");
  turn_gap_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_ff == AEMI_TURN |=> st_ff inside {AEMI_TURN, AEMI_SETUP})
    else $error("turnaround skipped");
  wait_sync_a: assert property (@(posedge clk) disable iff (!rst_n)
    w2_ff == $past(wait_in, 2) || $past(!rst_n, 2))
    else $error("wait sync depth wrong");
endmodule
`default_nettype wire

// File: rtl/aemi_pkg.sv
// constants and register layout for the async memory interface
// Behaviour
// - normal mode: select low whole cycle
// - strobe mode: select low only in strobe
// - mode bit 0 normal, 1 strobe
// - nand mode computes ecc per 512 bus transfers
// - lowest address pin is word address lsb
// - bank pins give byte/halfword address bits
// - 16-bit bus: low bank pin is address bit
// - separate read/write setup, strobe, hold counts
// - setup lasts setup field plus one cycles
// - strobe lasts strobe field plus one cycles
// - hold lasts hold field plus one cycles
// - turnaround field plus one idle cycles
// - no turnaround for same kind, same space
// - extended wait bit lets wait stretch strobe
// - four independent space configuration registers
// - new config used from next transfer
// - wait polarity bit selects active level
// - wait timeout after (max+1)*16 clocks, flagged
// - width 0 byte bus, 1 halfword; split requests
// - read/write select high reads, low writes
package aemi_pkg;
  localparam logic [11:0] ADDR_CFG0     = 12'h010;
  localparam logic [11:0] ADDR_WAITCFG  = 12'h004;
  localparam logic [11:0] ADDR_STATUS   = 12'h008;
  localparam logic [11:0] ADDR_ECC      = 12'h020;
  localparam int          CFG_SS        = 31;
  localparam int          CFG_EW        = 30;
  localparam int          CFG_WSU_LO    = 26;
  localparam int          CFG_WST_LO    = 20;
  localparam int          CFG_WHD_LO    = 17;
  localparam int          CFG_RSU_LO    = 13;
  localparam int          CFG_RST_LO    = 7;
  localparam int          CFG_RHD_LO    = 4;
  localparam int          CFG_TA_LO     = 2;
  localparam int          CFG_WIDTH_LO  = 0;
  localparam int          CFG_NAND      = 1;
  localparam logic [31:0] CFG_RESET     = 32'h3ffffffc;
  localparam int          WCFG_POL      = 28;
  localparam logic [31:0] WCFG_RESET    = 32'h100000ff;
  localparam int          WAIT_UNIT_LOG = 4;
  localparam logic [9:0]  ECC_BYTES     = 10'h200;
endpackage
